// [eesf_core.v]
/*
 * Serial command front end and status flags of a 128 x 16 EEPROM:
 * command decode, write-enable latch, ECC correction and flag, busy flag
 * and ready/busy pin, status output on serial out.
 * Assumes an outside word store answering mem_rd_req on the next clock,
 * and an outside self-timed write timer driving write_busy on sys_clk.
 */
`timescale 1ns/1ps
`include "eesf_defines.vh"

module eesf_core (
	input  wire                     sys_clk,         // 40 MHz system clock
	input  wire                     sys_rst,         // Synchronous reset, high
	input  wire                     cs_n,            // Chip select pin, low active
	input  wire                     sck,             // Serial clock pin
	input  wire                     serial_in,       // Serial data in pin
	input  wire                     rst_pin,         // Reset pin, high active
	output reg                      serial_out,      // Serial data out
	output reg                      serial_out_oe_n, // Output enable, low drives
	output reg                      rdy_busy_n,      // Ready high, busy low
	output reg                      write_halt,      // Reset pin seen, stop write
	input  wire                     write_busy,      // Self-timed write running
	output reg  [`EESF_ADDR_W-1:0]  mem_addr,        // Word address
	output reg                      mem_rd_req,      // Read pulse
	input  wire [`EESF_WORD_W-1:0]  mem_rdata,       // Stored word, next cycle
	output reg                      mem_wr_req,      // Write start pulse
	output reg  [`EESF_WORD_W-1:0]  mem_wdata,       // Word with check bits
	output wire                     wen_flag,        // Latch, 0 enabled
	output wire                     ecc_flag         // Last read corrected
);

	// One-hot frame states
	localparam [4:0] ST_HEAD  = 5'h01;
	localparam [4:0] ST_READ  = 5'h02;
	localparam [4:0] ST_WRITE = 5'h04;
	localparam [4:0] ST_STAT  = 5'h08;
	localparam [4:0] ST_DONE  = 5'h10;

	wire [3:0]                 pins_s;
	wire                       cs_n_s;
	wire                       sck_s;
	wire                       din_s;
	wire                       rstp_s;
	wire                       ctrl_clr;
	wire                       sck_rise;
	wire                       sck_fall;
	wire [7:0]                 byte_in;
	wire [7:0]                 fix_lo;
	wire [7:0]                 fix_hi;
	wire                       cor_lo;
	wire                       cor_hi;
	wire                       status_bit;

	reg                        sck_d_r;
	reg  [4:0]                 state_r;
	reg  [4:0]                 state_nxt;
	reg  [`EESF_CNT_W-1:0]     cnt_r;
	reg  [7:0]                 shift_r;
	reg  [`EESF_DATA_W-1:0]    wdat_r;
	reg  [1:0]                 sel_r;
	reg                        stat_on_r;
	reg                        rd_pend_r;
	reg  [`EESF_DATA_W-1:0]    rword_r;
	reg                        ecc_pend_r;
	reg                        ecc_r;
	reg                        wel_r;

	// ====================================================================
	// Pin synchronisers
	eesf_sync #(
		.WIDTH    (4)
	) u_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in ({rst_pin, serial_in, sck, cs_n}),
		.rst_val  (4'h3),
		.sync_out (pins_s)
	);

	assign cs_n_s = pins_s[0];
	assign sck_s  = pins_s[1];
	assign din_s  = pins_s[2];
	assign rstp_s = pins_s[3];

	// Controller is held clear by chip select high or the reset pin
	assign ctrl_clr = cs_n_s | rstp_s;
	assign sck_rise = sck_s & ~sck_d_r;
	assign sck_fall = ~sck_s & sck_d_r;
	assign byte_in  = {shift_r[6:0], din_s};

	// ====================================================================
	// Check bit generator, used for both bytes of a written word
	function [3:0] chk_bits;
		input [7:0] d;
		begin
			chk_bits[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
			chk_bits[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
			chk_bits[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
			chk_bits[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
		end
	endfunction

	// ====================================================================
	// Per-byte correction of the fetched word
	// one fix per byte
	eesf_ecc_byte u_ecc_lo (
		.raw_data  (mem_rdata[7:0]),
		.raw_chk   (mem_rdata[`EESF_CHK_LO_LSB+3:`EESF_CHK_LO_LSB]),
		.fix_data  (fix_lo),
		.corrected (cor_lo)
	);

	eesf_ecc_byte u_ecc_hi (
		.raw_data  (mem_rdata[15:8]),
		.raw_chk   (mem_rdata[`EESF_CHK_HI_LSB+3:`EESF_CHK_HI_LSB]),
		.fix_data  (fix_hi),
		.corrected (cor_hi)
	);

	// ====================================================================
	// Frame state: decided by the mode byte on the eighth rise
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_HEAD: begin
				if (sck_rise && cnt_r == `EESF_CNT_MODE) begin
					case (byte_in)
						`EESF_CMD_READ:   state_nxt = ST_READ;
						`EESF_CMD_WRITE:  state_nxt = ST_WRITE;
						`EESF_CMD_STATUS: state_nxt = ST_STAT;
						default:          state_nxt = ST_DONE;
					endcase
				end
			end
			ST_READ, ST_WRITE: begin
				if (sck_rise && cnt_r == `EESF_CNT_LAST)
					state_nxt = ST_DONE;
			end
			ST_STAT: state_nxt = ST_STAT;
			ST_DONE: state_nxt = ST_DONE;
			default: state_nxt = ST_HEAD;
		endcase
	end

	// ====================================================================
	// Sequencer registers; state, count and shift cleared while chip select is high
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			sck_d_r <= 1'b1;
			state_r <= ST_HEAD;
			cnt_r   <= {`EESF_CNT_W{1'b0}};
			shift_r <= 8'h00;
			wdat_r  <= 16'h0000;
			sel_r   <= 2'h0;
		end else begin
			sck_d_r <= sck_s;
			if (ctrl_clr) begin
				state_r <= ST_HEAD;
				cnt_r   <= {`EESF_CNT_W{1'b0}};
				shift_r <= 8'h00;
			end else begin
				state_r <= state_nxt;
				if (sck_rise) begin
					// Mode byte of a latch command held until byte two ends
					if (state_r != ST_DONE)
						shift_r <= byte_in;
					if (cnt_r != `EESF_CNT_LAST + 6'h01)
						cnt_r <= cnt_r + 6'h01;
					// Data bits arrive D0 first
					if (cnt_r >= `EESF_CNT_DATA0)
						wdat_r <= {din_s, wdat_r[15:1]};
					if (state_r == ST_STAT && cnt_r == `EESF_CNT_ADDR)
						sel_r <= byte_in[7:6];
				end
			end
		end
	end

	// ====================================================================
	// Address capture, A0 arrives first
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			mem_addr <= {`EESF_ADDR_W{1'b0}};
		end else if (!ctrl_clr && sck_rise && cnt_r == `EESF_CNT_ADDR &&
				(state_r == ST_READ || state_r == ST_WRITE)) begin
			mem_addr <= {shift_r[0], shift_r[1], shift_r[2], shift_r[3],
				shift_r[4], shift_r[5], shift_r[6]};
		end
	end

	// ====================================================================
	// Write-enable latch: no reset, only the two latch commands touch it
	// no initial state
	always @(posedge sys_clk) begin
		if (!sys_rst && !ctrl_clr && sck_rise && state_r == ST_DONE &&
				cnt_r == `EESF_CNT_ADDR) begin
			case (shift_r)
				`EESF_CMD_WEN:  wel_r <= `EESF_WEL_ENABLED;
				`EESF_CMD_WDIS: wel_r <= `EESF_WEL_DISABLED;
				default:        wel_r <= wel_r;
			endcase
		end
	end

	// ====================================================================
	// Write start on the 32nd rise
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			mem_wr_req <= 1'b0;
			mem_wdata  <= {`EESF_WORD_W{1'b0}};
		end else begin
			mem_wr_req <= 1'b0;
			if (!ctrl_clr && sck_rise && state_r == ST_WRITE &&
					cnt_r == `EESF_CNT_LAST && wel_r == `EESF_WEL_ENABLED &&
					!write_busy) begin
				mem_wr_req <= 1'b1;
				mem_wdata  <= {chk_bits({din_s, wdat_r[15:9]}), chk_bits(wdat_r[8:1]),
					din_s, wdat_r[15:1]};
			end
		end
	end

	// ====================================================================
	// Read fetch after the address byte, latch not consulted
	// reads ignore latch
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			mem_rd_req <= 1'b0;
			rd_pend_r  <= 1'b0;
			rword_r    <= 16'h0000;
			ecc_pend_r <= 1'b0;
		end else begin
			mem_rd_req <= !ctrl_clr && sck_rise && state_r == ST_READ &&
				cnt_r == `EESF_CNT_ADDR;
			rd_pend_r  <= mem_rd_req;
			if (rd_pend_r) begin
				rword_r    <= {fix_hi, fix_lo};
				ecc_pend_r <= cor_hi | cor_lo;
			end
		end
	end

	// ====================================================================
	// ECC flag committed when the read frame completes
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ecc_r <= 1'b0;
		end else if (!ctrl_clr && sck_rise && state_r == ST_READ &&
				cnt_r == `EESF_CNT_LAST) begin
			ecc_r <= ecc_pend_r;
		end
	end

	// ====================================================================
	// Ready/busy pin and write halt
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			rdy_busy_n <= 1'b1;
			write_halt <= 1'b0;
		end else begin
			rdy_busy_n <= ~write_busy;
			write_halt <= rstp_s;
		end
	end

	assign status_bit = (sel_r == `EESF_SEL_WEN) ? wel_r :
		(sel_r == `EESF_SEL_ECC) ? ecc_r :
		(sel_r == `EESF_SEL_BUSY) ? rdy_busy_n : 1'b1;

	// ====================================================================
	// Serial out: read data on falls 16..31, status from fall 16 onward
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			serial_out      <= 1'b1;
			serial_out_oe_n <= 1'b1;
			stat_on_r       <= 1'b0;
		end else if (ctrl_clr) begin
			serial_out      <= 1'b1;
			serial_out_oe_n <= 1'b1;
			stat_on_r       <= 1'b0;
		end else if (stat_on_r) begin
			serial_out      <= status_bit;
			serial_out_oe_n <= 1'b0;
		end else if (sck_fall && cnt_r == `EESF_CNT_DATA0 && state_r == ST_STAT) begin
			stat_on_r       <= 1'b1;
			serial_out      <= status_bit;
			serial_out_oe_n <= 1'b0;
		end else if (sck_fall && state_r == ST_READ && cnt_r >= `EESF_CNT_DATA0) begin
			serial_out      <= rword_r[cnt_r[3:0]];
			serial_out_oe_n <= 1'b0;
		end else if (sck_fall && state_r != ST_READ) begin
			serial_out_oe_n <= 1'b1;
		end
	end

	assign wen_flag = wel_r;
	assign ecc_flag = ecc_r;

endmodule // eesf_core

// [eesf_core_sva.sv]
/* Checker of the status-flag core: pins, busy, latch, flag and strobes.
   Assumes it is bound to the core, one clock, synchronous reset. */
`timescale 1ns/1ps
module eesf_core_sva (
	input wire sys_clk,         // System clock
	input wire sys_rst,         // Synchronous reset
	input wire cs_n,            // Chip select pin
	input wire rst_pin,         // Reset pin
	input wire serial_out,      // Data out
	input wire serial_out_oe_n, // Output enable, low drives
	input wire rdy_busy_n,      // Ready/busy pin
	input wire write_halt,      // Write stop
	input wire write_busy,      // Write timer
	input wire mem_rd_req,      // Read strobe
	input wire mem_wr_req,      // Write strobe
	input wire wen_flag,        // Latch
	input wire ecc_flag         // Correction flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	reg [7:0] since_rd_r; // Cycles since last read strobe

	// ==========
	// Read age counter, saturating
	always @(posedge sys_clk) begin
		if (sys_rst)
			since_rd_r <= 8'hFF;
		else if (mem_rd_req)
			since_rd_r <= 8'h00;
		else if (since_rd_r != 8'hFF)
			since_rd_r <= since_rd_r + 8'h01;
	end

	// ==========
	// pin follows timer
	AST_BUSY_PIN: assert property ($stable(write_busy) && !$past(sys_rst)
		|-> rdy_busy_n != write_busy)
		else $error("busy pin differs from timer");
	AST_WR_GATE: assert property (mem_wr_req |-> !wen_flag && !$past(write_busy))
		else $error("write started while not allowed");
	AST_WR_PULSE: assert property (mem_wr_req |=> !mem_wr_req)
		else $error("write strobe too long");
	AST_RD_ONCE: assert property (mem_rd_req |=> !mem_rd_req [*8])
		else $error("read strobe repeated");
	AST_WEL_HOLD: assert property (!$stable(wen_flag) |-> !$past(cs_n, 4))
		else $error("latch changed outside a frame");
	AST_ECC_HOLD: assert property (!$stable(ecc_flag) && !$past(sys_rst)
		|-> since_rd_r > 8'h64 && since_rd_r < 8'hA0)
		else $error("flag changed away from read end");
	AST_DESELECT: assert property ($rose(cs_n) |-> ##[1:6] serial_out_oe_n)
		else $error("output not released");
	AST_IDLE_OUT: assert property (cs_n && $past(cs_n, 6)
		|-> serial_out_oe_n && serial_out)
		else $error("output not idle");
	AST_HALT: assert property ($rose(rst_pin) |-> ##[1:4] write_halt)
		else $error("halt not raised");

	cover property (mem_wr_req);
	cover property ($rose(ecc_flag));
	cover property (!serial_out_oe_n && !rdy_busy_n);
endmodule // eesf_core_sva

// [eesf_defines.vh]
/*
 * Shared constants of the EEPROM status-flag logic: command codes,
 * status select codes, frame bit counts, stored word layout.
 * Assumes inclusion by bare name from each design file of the block.
 */
`ifndef EESF_DEFINES_VH
`define EESF_DEFINES_VH

// ====================================================================
// Command bytes, first bit on the wire is bit 7
`define EESF_CMD_READ      8'hA8
`define EESF_CMD_WRITE     8'hA4
`define EESF_CMD_WEN       8'hA3
`define EESF_CMD_WDIS      8'hA0
`define EESF_CMD_STATUS    8'hA9

// ====================================================================
// Status select, two leading bits of the second byte
`define EESF_SEL_BUSY      2'h0
`define EESF_SEL_WEN       2'h2
`define EESF_SEL_ECC       2'h1

// ====================================================================
// Frame counts of rising clock edges, counted from zero
`define EESF_CNT_W         6
`define EESF_CNT_MODE      6'h07
`define EESF_CNT_ADDR      6'h0F
`define EESF_CNT_DATA0     6'h10
`define EESF_CNT_LAST      6'h1F

// ====================================================================
// Stored word: data plus four check bits per byte
`define EESF_ADDR_W        7
`define EESF_DATA_W        16
`define EESF_WORD_W        24
`define EESF_CHK_LO_LSB    16
`define EESF_CHK_HI_LSB    20

// ====================================================================
// Write-enable latch values, zero means writes allowed
`define EESF_WEL_ENABLED   1'b0
`define EESF_WEL_DISABLED  1'b1

`endif

// [eesf_ecc_byte.v]
/*
 * Single-error corrector for one byte held with four Hamming check bits.
 * Assumes check bits were made with the same code by the write path.
 */
`timescale 1ns/1ps

module eesf_ecc_byte (
	input  wire [7:0] raw_data,  // Stored data byte
	input  wire [3:0] raw_chk,   // Stored check bits p8 p4 p2 p1
	output reg  [7:0] fix_data,  // Corrected data byte
	output wire       corrected  // A single error was found
);

	wire [3:0] calc;
	wire [3:0] syn;

	// ====================================================================
	// Recompute check bits and form the syndrome
	assign calc[0] = raw_data[0] ^ raw_data[1] ^ raw_data[3] ^ raw_data[4] ^ raw_data[6];
	assign calc[1] = raw_data[0] ^ raw_data[2] ^ raw_data[3] ^ raw_data[5] ^ raw_data[6];
	assign calc[2] = raw_data[1] ^ raw_data[2] ^ raw_data[3] ^ raw_data[7];
	assign calc[3] = raw_data[4] ^ raw_data[5] ^ raw_data[6] ^ raw_data[7];
	assign syn       = calc ^ raw_chk;
	assign corrected = (syn != 4'h0);

	// Flip the data bit the syndrome points at
	always @* begin
		fix_data = raw_data;
		case (syn)
			4'h3: fix_data[0] = ~raw_data[0];
			4'h5: fix_data[1] = ~raw_data[1];
			4'h6: fix_data[2] = ~raw_data[2];
			4'h7: fix_data[3] = ~raw_data[3];
			4'h9: fix_data[4] = ~raw_data[4];
			4'hA: fix_data[5] = ~raw_data[5];
			4'hB: fix_data[6] = ~raw_data[6];
			4'hC: fix_data[7] = ~raw_data[7];
			default: fix_data = raw_data;
		endcase
	end

endmodule // eesf_ecc_byte

// [eesf_host.sv]
/* Host model: drives chip select, serial clock and data, samples data out.
   Assumes a 25 ns system clock; serial clock is 8 cycles, idle high. */
`timescale 1ns/1ps
module eesf_host (
	input  wire sys_clk,    // System clock
	input  wire serial_out, // Device data out
	output reg  cs_n,       // Chip select
	output reg  sck,        // Serial clock
	output reg  serial_in   // Data to device
);
	// ==========
	// Idle levels
	initial begin
		cs_n = 1'b1;
		sck = 1'b1;
		serial_in = 1'b0;
	end

	// Send tx[0] first; rx[i] taken late in high phase of clock i
	task frame(input [31:0] tx, input integer n, output [31:0] rx);
		integer i;
		begin
			rx = 32'h0;
			if (cs_n) begin
				@(posedge sys_clk) cs_n <= 1'b0;
				repeat (4) @(posedge sys_clk);
			end
			for (i = 0; i < n; i = i + 1) begin
				@(posedge sys_clk) sck <= 1'b0;
				serial_in <= tx[i];
				repeat (4) @(posedge sys_clk);
				sck <= 1'b1;
				repeat (3) @(posedge sys_clk);
				rx[i] = serial_out;
			end
		end
	endtask

	// Close frame; data line shows inverse of its last level
	task done;
		begin
			repeat (2) @(posedge sys_clk);
			cs_n <= 1'b1;
			serial_in <= ~serial_in;
			repeat (8) @(posedge sys_clk);
		end
	endtask
endmodule // eesf_host

// [eesf_sync.v]
/*
 * Two-flop synchronisers for the asynchronous serial pins.
 * Assumes pins are quasi-static relative to the 25 ns system clock.
 */
`timescale 1ns/1ps

module eesf_sync #(
	parameter WIDTH = 4
) (
	input  wire             sys_clk,  // System clock
	input  wire             sys_rst,  // Synchronous reset, high
	input  wire [WIDTH-1:0] async_in, // Raw pin levels
	input  wire [WIDTH-1:0] rst_val,  // Level shown during reset
	output wire [WIDTH-1:0] sync_out  // Synchronised levels
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// ====================================================================
	// Two stages per bit, first stage read only by the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge sys_clk) begin
				// Reset to the idle level, so no false edge follows reset
				if (sys_rst) begin
					meta_r[i] <= rst_val[i];
					sync_r[i] <= rst_val[i];
				end else begin
					meta_r[i] <= async_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
			assign sync_out[i] = sys_rst ? rst_val[i] : sync_r[i];
		end
	endgenerate

endmodule // eesf_sync

// [tb.sv]
/* Bench for the status-flag core: host model, word store, write timer.
   Assumes core, header, host model and checker are compiled first. */
`timescale 1ns/1ps
`include "eesf_defines.vh"
module tb;
	reg         sys_clk, sys_rst, rst_pin, write_busy;
	reg  [23:0] mem_rdata;
	wire        cs_n, sck, serial_in, serial_out, serial_out_oe_n, rdy_busy_n;
	wire        write_halt, mem_rd_req, mem_wr_req, wen_flag, ecc_flag;
	wire [6:0]  mem_addr;
	wire [23:0] mem_wdata;
	reg  [23:0] mem [0:127];
	reg  [31:0] rx;
	reg  [15:0] d;
	integer     cyc, busy_cnt, wr_cnt, n_mismatch, total_checks, k;

	eesf_core u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck),
		.serial_in(serial_in), .rst_pin(rst_pin), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .rdy_busy_n(rdy_busy_n),
		.write_halt(write_halt), .write_busy(write_busy), .mem_addr(mem_addr),
		.mem_rd_req(mem_rd_req), .mem_rdata(mem_rdata), .mem_wr_req(mem_wr_req),
		.mem_wdata(mem_wdata), .wen_flag(wen_flag), .ecc_flag(ecc_flag));
	eesf_host u_host (.sys_clk(sys_clk), .serial_out(serial_out), .cs_n(cs_n),
		.sck(sck), .serial_in(serial_in));

	always #12.5 sys_clk = ~sys_clk;

	// ==========
	// Word store, write timer, run limit
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		mem_rdata <= mem_rd_req ? mem[mem_addr] : ~mem_rdata;
		if (mem_wr_req) begin
			mem[mem_addr] <= mem_wdata;
			wr_cnt <= wr_cnt + 1;
			busy_cnt <= 400;
		end else if (busy_cnt != 0)
			busy_cnt <= busy_cnt - 1;
		write_busy <= mem_wr_req || busy_cnt > 1;
		if (cyc == 30000) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end

	function [3:0] chk(input [7:0] b);
		chk = {^(b & 8'hF0), ^(b & 8'h8E), ^(b & 8'h6D), ^(b & 8'h5B)};
	endfunction
	function [31:0] fr(input [7:0] c, input [7:0] b2, input [15:0] dat);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				fr[i] = c[7-i];
			fr[15:8] = b2;
			fr[31:16] = dat;
		end
	endfunction
	task check(input [79:0] nm, input [31:0] exp, input [31:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR %0s expected %0h seen %0h", nm, exp, got);
			end
		end
	endtask
	task cmd(input [7:0] c);
		begin
			u_host.frame(fr(c, 8'h00, 16'h0000), 16, rx);
			u_host.done;
		end
	endtask
	task wr(input [6:0] a, input [15:0] dat);
		begin
			u_host.frame(fr(`EESF_CMD_WRITE, {1'b0, a}, dat), 32, rx);
			u_host.done;
		end
	endtask
	task rd(input [6:0] a);
		begin
			u_host.frame(fr(`EESF_CMD_READ, {1'b0, a}, 16'h0000), 32, rx);
			u_host.done;
			d = rx[31:16];
		end
	endtask
	// Status frame, first select bit is sel[1]; left selected
	task stat(input [1:0] sel);
		u_host.frame(fr(`EESF_CMD_STATUS, {6'h00, sel[0], sel[1]}, 16'h0000), 17, rx);
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	// ==========
	// Main sequence
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		rst_pin = 1'b0;
		write_busy = 1'b0;
		mem_rdata = 24'h000000;
		{cyc, busy_cnt, wr_cnt, n_mismatch, total_checks} = 0;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check("wen_pwrup", 1'hX, wen_flag);
		cmd(`EESF_CMD_WEN);
		check("wen_first", 0, wen_flag);
		cmd(`EESF_CMD_WDIS);
		check("wen_flag", 1, wen_flag);
		wr(7'h05, 16'h1234);
		check("wr_count", 0, wr_cnt);
		stat(`EESF_SEL_WEN);
		check("stat_wen", 1, rx[16]);
		u_host.done;
		$display("test disable done");
		cmd(`EESF_CMD_WEN);
		check("wen_flag", 0, wen_flag);
		stat(`EESF_SEL_WEN);
		check("stat_wen", 0, rx[16]);
		u_host.done;
		wr(7'h05, 16'h1234);
		check("wr_count", 1, wr_cnt);
		check("stored", {chk(8'h12), chk(8'h34), 16'h1234}, mem[5]);
		stat(`EESF_SEL_BUSY);
		check("stat_busy", 0, rx[16]);
		check("rdy_pin", 0, rdy_busy_n);
		check("stat_oe", 0, serial_out_oe_n);
		for (k = 0; k < 600 && write_busy; k = k + 1)
			@(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
		check("stat_ready", 1, serial_out);
		u_host.done;
		rd(7'h05);
		check("rd_data", 16'h1234, d);
		check("wen_kept", 0, wen_flag);
		$display("test enable done");
		cmd(`EESF_CMD_WDIS);
		for (k = 0; k < 5; k = k + 1) begin
			mem[7'h14 + k[6:0]] = {chk(8'hC3), chk(8'h5A), 16'hC35A} ^ ((k == 0) ? 24'h000008 :
				(k == 2) ? 24'h001000 : (k == 3) ? 24'h001008 : (k == 4) ? 24'h020000 : 24'h0);
			rd(7'h14 + k[6:0]);
			check("ecc_data", 16'hC35A, d);
			stat(`EESF_SEL_ECC);
			check("stat_ecc", k != 1, rx[16]);
			check("ecc_flag", k != 1, ecc_flag);
			u_host.done;
		end
		$display("test ecc done");
		u_host.frame(fr(`EESF_CMD_WEN, 8'h00, 16'h0000), 10, rx);
		rst_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		check("halt_pin", 1, write_halt);
		rst_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
		u_host.frame(fr(`EESF_CMD_WEN, 8'h00, 16'h0000) >> 10, 6, rx);
		u_host.done;
		check("wen_abort", 1, wen_flag);
		$display("test abort done");
		finish_test;
	end
endmodule // tb

bind eesf_core eesf_core_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n),
	.rst_pin(rst_pin), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
	.rdy_busy_n(rdy_busy_n), .write_halt(write_halt), .write_busy(write_busy),
	.mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .wen_flag(wen_flag),
	.ecc_flag(ecc_flag));
